// >>> rtl/ipoc_pkg.sv
// Constants and types shared by the pin option configuration block.
package ipoc_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register indices; each byte address is four times the index.
	localparam logic [9:0] REG_PORT1_INDEX = 10'h09F;
	localparam logic [9:0] REG_PORT2_INDEX = 10'h097;
	localparam int ADDR_LSB = 2;

	////////////////////////////////////////////////////////////////////////
	// Field layout of the configuration byte.
	localparam int FUNC_MSB = 7;
	localparam int FUNC_LSB = 5;
	localparam int OUT_FUNC_MSB = 6;
	localparam int DIR_BIT = 4;
	localparam int LOAD_BIT = 3;
	localparam int INDEX_MSB = 2;
	localparam int INDEX_LSB = 0;
	localparam logic DIR_OUTPUT = 1'b0;
	localparam logic DIR_INPUT = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// Input function codes and reset values.
	localparam logic [2:0] IN_NO_PULL = 3'h0;
	localparam logic [2:0] IN_PULL_DOWN = 3'h1;
	localparam logic [2:0] IN_PULL_UP_WEAK = 3'h2;
	localparam logic [2:0] IN_PULL_UP_STRONG = 3'h3;
	localparam logic [2:0] IN_BUFFER_OFF = 3'h7;
	localparam logic [2:0] IN_MODE_RESET = IN_PULL_DOWN;
	localparam logic [1:0] OUT_MODE_RESET = 2'h0;
	localparam logic [2:0] PTR_INDEX_RESET = 3'h0;
	localparam logic PTR_DIR_RESET = DIR_OUTPUT;

	////////////////////////////////////////////////////////////////////////
	// Bus responses and state encodings.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		W_COLLECT = 2'b00,
		W_COMMIT = 2'b01,
		W_RESP = 2'b10
	} ipoc_wr_state_t;

	typedef enum logic [0:0] {
		R_IDLE = 1'b0,
		R_DATA = 1'b1
	} ipoc_rd_state_t;

	// Pad controls of one pin.
	typedef struct packed {
		logic [1:0] drive;
		logic in_buf_en;
		logic pull_down;
		logic pull_up_weak;
		logic pull_up_strong;
	} ipoc_pad_t;

endpackage : ipoc_pkg

// >>> rtl/ipoc_bank.sv
// Mode storage and readback pointer for one port of up to eight pins.
`timescale 1ns/1ps
module ipoc_bank #(
	parameter int PINS = 8
) (
	input wire logic clock_i, // Core clock.
	input wire logic rstn_i, // Asynchronous reset, active low.
	input wire logic wr_i, // One-cycle write of the configuration byte.
	input wire logic [7:0] wdata_i, // Written configuration byte.
	output logic [7:0] rdata_o, // Readback byte.
	output logic [PINS-1:0][1:0] out_mode_o, // Stored output modes.
	output logic [PINS-1:0][2:0] in_mode_o // Stored input modes.
);

	if (PINS < 1 || PINS > 8) begin : g_bad_pins
		$error("ipoc_bank: PINS must be 1 to 8.");
	end

	typedef struct packed {
		logic [PINS-1:0][1:0] out_mode;
		logic [PINS-1:0][2:0] in_mode;
		logic [2:0] ptr_index;
		logic ptr_dir;
	} ipoc_bank_state_t;

	ipoc_bank_state_t st;
	ipoc_bank_state_t next_st;
	logic [2:0] func;
	logic [2:0] idx;
	logic dir;
	logic load;
	logic [2:0] rd_mode;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		func = wdata_i[ipoc_pkg::FUNC_MSB:ipoc_pkg::FUNC_LSB];
		idx = wdata_i[ipoc_pkg::INDEX_MSB:ipoc_pkg::INDEX_LSB];
		dir = wdata_i[ipoc_pkg::DIR_BIT];
		load = wdata_i[ipoc_pkg::LOAD_BIT];
		next_st = st;
		if (wr_i && load) begin
			next_st.ptr_index = idx;
			next_st.ptr_dir = dir;
		end
		for (int i = 0; i < PINS; i++) begin
			// Indices beyond the port's pins match no entry.
			if (wr_i && !load && idx == 3'(i)) begin
				if (dir == ipoc_pkg::DIR_INPUT) begin
					next_st.in_mode[i] = func;
				end else begin
					next_st.out_mode[i] = func[1:0];
				end
			end
		end
		rd_mode = 3'h0;
		for (int i = 0; i < PINS; i++) begin
			if (st.ptr_index == 3'(i)) begin
				if (st.ptr_dir == ipoc_pkg::DIR_INPUT) begin
					rd_mode = st.in_mode[i];
				end else begin
					rd_mode = {1'b0, st.out_mode[i]};
				end
			end
		end
		// The load bit holds no state and reads as zero.
		rdata_o = {rd_mode, st.ptr_dir, 1'b0, st.ptr_index};
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st.out_mode <= {PINS{ipoc_pkg::OUT_MODE_RESET}};
			st.in_mode <= {PINS{ipoc_pkg::IN_MODE_RESET}};
			st.ptr_index <= ipoc_pkg::PTR_INDEX_RESET;
			st.ptr_dir <= ipoc_pkg::PTR_DIR_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign out_mode_o = st.out_mode;
	assign in_mode_o = st.in_mode;

endmodule : ipoc_bank

// >>> rtl/ipoc_pad_decode.sv
// Translation of stored pin modes into pad control signals.
`timescale 1ns/1ps
module ipoc_pad_decode #(
	parameter int PINS = 8
) (
	input wire logic [PINS-1:0][1:0] out_mode_i, // Stored output modes.
	input wire logic [PINS-1:0][2:0] in_mode_i, // Stored input modes.
	output ipoc_pkg::ipoc_pad_t [PINS-1:0] pad_o // Pad controls per pin.
);

	if (PINS < 1) begin : g_bad_pins
		$error("ipoc_pad_decode: PINS must be at least 1.");
	end

	////////////////////////////////////////////////////////////////////////
	for (genvar g = 0; g < PINS; g++) begin : g_pin
		logic [2:0] code;
		assign code = in_mode_i[g];
		assign pad_o[g].drive = out_mode_i[g];
		// Reserved codes turn the buffer off so no pull is left floating.
		assign pad_o[g].in_buf_en = (code == ipoc_pkg::IN_NO_PULL)
			|| (code == ipoc_pkg::IN_PULL_DOWN)
			|| (code == ipoc_pkg::IN_PULL_UP_WEAK)
			|| (code == ipoc_pkg::IN_PULL_UP_STRONG);
		assign pad_o[g].pull_down = (code == ipoc_pkg::IN_PULL_DOWN);
		assign pad_o[g].pull_up_weak =
			(code == ipoc_pkg::IN_PULL_UP_WEAK);
		assign pad_o[g].pull_up_strong =
			(code == ipoc_pkg::IN_PULL_UP_STRONG);
	end

endmodule : ipoc_pad_decode

// >>> rtl/ipoc_top.sv
// AXI4-Lite register slave for the port 1 and port 2 pin option settings.
//
// Operation
// - Write without pointer load stores the code as the pin's mode.
// - Pointer load write saves index and direction; modes unchanged.
// - Read returns in bits 7:5 the mode selected by the saved pointer.
// - Bit 4 low selects output, high selects input configuration.
// - Output modes use bits 6:5, 00 weakest to 11 strongest drive.
// - Input codes 000 no pull, 001 pull-down default, 010/011 pull-ups.
// - Input code 111 disables the input buffer; 100 to 110 are reserved.
// - Port 1 index in bits 2:0 selects pin 0 to 7 directly.
// - Port 2 accepts only index 0 and 1; others address no pin.
`timescale 1ns/1ps
module ipoc_top #(
	parameter int ADDR_W = 12,
	parameter int PORT1_PINS = 8,
	parameter int PORT2_PINS = 2
) (
	input wire logic clock_i, // Core clock, 40 MHz.
	input wire logic rstn_i, // Asynchronous reset, active low.
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i, // Write address.
	input wire logic s_axi_awvalid_i, // Write address valid.
	output logic s_axi_awready_o, // Write address ready.
	input wire logic [31:0] s_axi_wdata_i, // Write data.
	input wire logic [3:0] s_axi_wstrb_i, // Write byte strobes.
	input wire logic s_axi_wvalid_i, // Write data valid.
	output logic s_axi_wready_o, // Write data ready.
	output logic [1:0] s_axi_bresp_o, // Write response.
	output logic s_axi_bvalid_o, // Write response valid.
	input wire logic s_axi_bready_i, // Write response ready.
	input wire logic [ADDR_W-1:0] s_axi_araddr_i, // Read address.
	input wire logic s_axi_arvalid_i, // Read address valid.
	output logic s_axi_arready_o, // Read address ready.
	output logic [31:0] s_axi_rdata_o, // Read data.
	output logic [1:0] s_axi_rresp_o, // Read response.
	output logic s_axi_rvalid_o, // Read data valid.
	input wire logic s_axi_rready_i, // Read data ready.
	output ipoc_pkg::ipoc_pad_t [PORT1_PINS-1:0] port1_pad_o, // Port 1 pads.
	output ipoc_pkg::ipoc_pad_t [PORT2_PINS-1:0] port2_pad_o // Port 2 pads.
);

	localparam int WORD_W = ADDR_W - ipoc_pkg::ADDR_LSB;

	if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr_w
		$error("ipoc_top: ADDR_W must be 12 to 32.");
	end
	if (PORT1_PINS < 1 || PORT1_PINS > 8) begin : g_bad_port1_pins
		$error("ipoc_top: PORT1_PINS must be 1 to 8.");
	end
	if (PORT2_PINS < 1 || PORT2_PINS > 8) begin : g_bad_port2_pins
		$error("ipoc_top: PORT2_PINS must be 1 to 8.");
	end

	typedef struct packed {
		ipoc_pkg::ipoc_wr_state_t wst;
		ipoc_pkg::ipoc_rd_state_t rst;
		logic aw_got;
		logic w_got;
		logic [WORD_W-1:0] aw_word;
		logic [7:0] wbyte;
		logic wlane0;
		logic [1:0] bresp;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ipoc_top_state_t;

	ipoc_top_state_t st;
	ipoc_top_state_t next_st;

	logic aw_hs;
	logic w_hs;
	logic ar_hs;
	logic aw_done;
	logic w_done;
	logic wr_hit1;
	logic wr_hit2;
	logic port1_wr;
	logic port2_wr;
	logic [WORD_W-1:0] ar_word;
	logic [7:0] port1_rdata;
	logic [7:0] port2_rdata;
	logic [PORT1_PINS-1:0][1:0] port1_out_mode;
	logic [PORT1_PINS-1:0][2:0] port1_in_mode;
	logic [PORT2_PINS-1:0][1:0] port2_out_mode;
	logic [PORT2_PINS-1:0][2:0] port2_in_mode;

	////////////////////////////////////////////////////////////////////////
	// Handshakes and address decode.
	assign s_axi_awready_o = (st.wst == ipoc_pkg::W_COLLECT) && !st.aw_got;
	assign s_axi_wready_o = (st.wst == ipoc_pkg::W_COLLECT) && !st.w_got;
	assign s_axi_arready_o = (st.rst == ipoc_pkg::R_IDLE);
	assign aw_hs = s_axi_awvalid_i && s_axi_awready_o;
	assign w_hs = s_axi_wvalid_i && s_axi_wready_o;
	assign ar_hs = s_axi_arvalid_i && s_axi_arready_o;
	assign aw_done = st.aw_got || aw_hs;
	assign w_done = st.w_got || w_hs;
	assign ar_word = s_axi_araddr_i[ADDR_W-1:ipoc_pkg::ADDR_LSB];

	assign wr_hit1 = (st.aw_word == WORD_W'(ipoc_pkg::REG_PORT1_INDEX));
	assign wr_hit2 = (st.aw_word == WORD_W'(ipoc_pkg::REG_PORT2_INDEX));

	// A write with lane 0 off is answered but changes nothing.
	assign port1_wr = (st.wst == ipoc_pkg::W_COMMIT) && wr_hit1
		&& st.wlane0;
	assign port2_wr = (st.wst == ipoc_pkg::W_COMMIT) && wr_hit2
		&& st.wlane0;

	////////////////////////////////////////////////////////////////////////
	// Bus state machines.
	always_comb begin
		next_st = st;
		case (st.wst)
			ipoc_pkg::W_COLLECT: begin
				if (aw_hs) begin
					next_st.aw_got = 1'b1;
					next_st.aw_word =
						s_axi_awaddr_i[ADDR_W-1:ipoc_pkg::ADDR_LSB];
				end
				if (w_hs) begin
					next_st.w_got = 1'b1;
					next_st.wbyte = s_axi_wdata_i[7:0];
					next_st.wlane0 = s_axi_wstrb_i[0];
				end
				if (aw_done && w_done) begin
					next_st.wst = ipoc_pkg::W_COMMIT;
				end
			end
			ipoc_pkg::W_COMMIT: begin
				if (wr_hit1 || wr_hit2) begin
					next_st.bresp = ipoc_pkg::RESP_OKAY;
				end else begin
					next_st.bresp = ipoc_pkg::RESP_SLVERR;
				end
				next_st.wst = ipoc_pkg::W_RESP;
			end
			ipoc_pkg::W_RESP: begin
				if (s_axi_bready_i) begin
					next_st.wst = ipoc_pkg::W_COLLECT;
					next_st.aw_got = 1'b0;
					next_st.w_got = 1'b0;
				end
			end
			default: begin
				next_st.wst = ipoc_pkg::W_COLLECT;
				next_st.aw_got = 1'b0;
				next_st.w_got = 1'b0;
			end
		endcase
		case (st.rst)
			ipoc_pkg::R_IDLE: begin
				if (ar_hs) begin
					next_st.rst = ipoc_pkg::R_DATA;
					if (ar_word == WORD_W'(ipoc_pkg::REG_PORT1_INDEX)) begin
						next_st.rdata = {24'h000000, port1_rdata};
						next_st.rresp = ipoc_pkg::RESP_OKAY;
					end else if (ar_word ==
						WORD_W'(ipoc_pkg::REG_PORT2_INDEX)) begin
						next_st.rdata = {24'h000000, port2_rdata};
						next_st.rresp = ipoc_pkg::RESP_OKAY;
					end else begin
						next_st.rdata = 32'h00000000;
						next_st.rresp = ipoc_pkg::RESP_SLVERR;
					end
				end
			end
			ipoc_pkg::R_DATA: begin
				if (s_axi_rready_i) begin
					next_st.rst = ipoc_pkg::R_IDLE;
				end
			end
			default: begin
				next_st.rst = ipoc_pkg::R_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st.wst <= ipoc_pkg::W_COLLECT;
			st.rst <= ipoc_pkg::R_IDLE;
			st.aw_got <= 1'b0;
			st.w_got <= 1'b0;
			st.aw_word <= '0;
			st.wbyte <= 8'h00;
			st.wlane0 <= 1'b0;
			st.bresp <= ipoc_pkg::RESP_OKAY;
			st.rdata <= 32'h00000000;
			st.rresp <= ipoc_pkg::RESP_OKAY;
		end else begin
			st <= next_st;
		end
	end

	assign s_axi_bvalid_o = (st.wst == ipoc_pkg::W_RESP);
	assign s_axi_bresp_o = st.bresp;
	assign s_axi_rvalid_o = (st.rst == ipoc_pkg::R_DATA);
	assign s_axi_rdata_o = st.rdata;
	assign s_axi_rresp_o = st.rresp;

	////////////////////////////////////////////////////////////////////////
	// Port banks and pad decoders.
	ipoc_bank #(
		.PINS(PORT1_PINS)
	) u_port1_bank (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.wr_i(port1_wr),
		.wdata_i(st.wbyte),
		.rdata_o(port1_rdata),
		.out_mode_o(port1_out_mode),
		.in_mode_o(port1_in_mode)
	);

	ipoc_bank #(
		.PINS(PORT2_PINS)
	) u_port2_bank (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.wr_i(port2_wr),
		.wdata_i(st.wbyte),
		.rdata_o(port2_rdata),
		.out_mode_o(port2_out_mode),
		.in_mode_o(port2_in_mode)
	);

	ipoc_pad_decode #(
		.PINS(PORT1_PINS)
	) u_port1_decode (
		.out_mode_i(port1_out_mode),
		.in_mode_i(port1_in_mode),
		.pad_o(port1_pad_o)
	);

	ipoc_pad_decode #(
		.PINS(PORT2_PINS)
	) u_port2_decode (
		.out_mode_i(port2_out_mode),
		.in_mode_i(port2_in_mode),
		.pad_o(port2_pad_o)
	);

endmodule : ipoc_top

// >>> tb/ipoc_chk.sv
// Concurrent checks on the register bus and port 1 pads.
`timescale 1ns/1ps
module ipoc_chk #(
	parameter int PORT1_PINS = 8
) (
	input wire logic clock_i, // Clock.
	input wire logic rstn_i, // Reset.
	input wire logic s_axi_awvalid_i, // AW valid.
	input wire logic s_axi_awready_o, // AW ready.
	input wire logic s_axi_wvalid_i, // W valid.
	input wire logic s_axi_wready_o, // W ready.
	input wire logic s_axi_bvalid_o, // B valid.
	input wire logic s_axi_bready_i, // B ready.
	input wire logic s_axi_arvalid_i, // AR valid.
	input wire logic s_axi_arready_o, // AR ready.
	input wire logic [31:0] s_axi_rdata_o, // R data.
	input wire logic s_axi_rvalid_o, // R valid.
	input wire logic s_axi_rready_i, // R ready.
	input wire ipoc_pkg::ipoc_pad_t [PORT1_PINS-1:0] port1_pad_o // Pads.
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	sequence s_wr_take;
		s_axi_awvalid_i && s_axi_awready_o
		&& s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	sequence s_commit;
		!s_axi_bvalid_o && !s_axi_awready_o && !s_axi_wready_o;
	endsequence
	a_bvalid_delay: assert property (
		s_wr_take |=> s_commit ##1 s_axi_bvalid_o) else $error("late bvalid");
	a_bvalid_drop: assert property (
		s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o
		&& s_axi_awready_o && s_axi_wready_o)
		else $error("write channel not freed");
	a_rvalid_next: assert property (
		s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("late rvalid");
	a_rvalid_drop: assert property (
		s_axi_rvalid_o && s_axi_rready_i
		|=> !s_axi_rvalid_o && s_axi_arready_o)
		else $error("read channel not freed");
	a_ar_block: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("arready while rvalid");
	a_load_zero: assert property (
		s_axi_rvalid_o
		|-> s_axi_rdata_o[3] == 1'b0 && s_axi_rdata_o[31:8] == 24'h000000)
		else $error("load bit or upper bits read nonzero");
	a_out_bit7: assert property (
		s_axi_rvalid_o && !s_axi_rdata_o[4] |-> !s_axi_rdata_o[7])
		else $error("output mode bit 7 set");
	a_pad_commit: assert property (
		$changed(port1_pad_o) |-> $rose(s_axi_bvalid_o))
		else $error("pads changed outside a write commit");
endmodule : ipoc_chk
bind ipoc_top ipoc_chk #(.PORT1_PINS(PORT1_PINS)) chk_u (.clock_i, .rstn_i,
	.s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
	.s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o,
	.s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i, .port1_pad_o);

// >>> tb/ipoc_axi_mst.sv
// Software side model: an AXI4-Lite master issuing one access at a time.
`timescale 1ns/1ps
module ipoc_axi_mst (
	input wire logic clock_i, // Clock.
	output logic [11:0] awaddr_o, // AW addr.
	output logic awvalid_o, // AW valid.
	input wire logic awready_i, // AW ready.
	output logic [31:0] wdata_o, // W data.
	output logic [3:0] wstrb_o, // W strobes.
	output logic wvalid_o, // W valid.
	input wire logic wready_i, // W ready.
	input wire logic [1:0] bresp_i, // B resp.
	input wire logic bvalid_i, // B valid.
	output logic bready_o, // B ready.
	output logic [11:0] araddr_o, // AR addr.
	output logic arvalid_o, // AR valid.
	input wire logic arready_i, // AR ready.
	input wire logic [31:0] rdata_i, // R data.
	input wire logic [1:0] rresp_i, // R resp.
	input wire logic rvalid_i, // R valid.
	output logic rready_o // R ready.
);
	initial begin
		{awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o} = '0;
		{bready_o, araddr_o, arvalid_o, rready_o} = '0;
	end
	// One byte, one pin and one direction per write.
	task wr(input logic [11:0] a, input logic [7:0] d, input logic s,
		output logic [1:0] r);
		logic ta, tw, da, dw, b;
		da = 0;
		dw = 0;
		@(posedge clock_i);
		awaddr_o <= a;
		wdata_o <= {24'h000000, d};
		wstrb_o <= {3'h0, s};
		awvalid_o <= 1'b1;
		wvalid_o <= 1'b1;
		bready_o <= 1'b1;
		while (!(da && dw)) begin
			@(negedge clock_i);
			ta = awvalid_o && awready_i;
			tw = wvalid_o && wready_i;
			@(posedge clock_i);
			if (ta) begin
				awvalid_o <= 1'b0;
				awaddr_o <= ~a;
				da = 1;
			end
			if (tw) begin
				wvalid_o <= 1'b0;
				wdata_o <= ~wdata_o;
				dw = 1;
			end
		end
		do begin
			@(negedge clock_i);
			b = bvalid_i;
			r = bresp_i;
			@(posedge clock_i);
		end while (!b);
		bready_o <= 1'b0;
	endtask : wr
	task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic v;
		@(posedge clock_i);
		araddr_o <= a;
		arvalid_o <= 1'b1;
		rready_o <= 1'b1;
		do begin
			@(negedge clock_i);
			v = arready_i;
			@(posedge clock_i);
		end while (!v);
		arvalid_o <= 1'b0;
		araddr_o <= ~a;
		do begin
			@(negedge clock_i);
			v = rvalid_i;
			d = rdata_i;
			r = rresp_i;
			@(posedge clock_i);
		end while (!v);
		rready_o <= 1'b0;
	endtask : rd
endmodule : ipoc_axi_mst

// >>> tb/tb.sv
// Self-checking bench for the pin option configuration block.
`timescale 1ns/1ps
module tb;
	logic clock_i, rstn_i, awv, awr, wv, wr_, bv, br, arv, arr, rv, rr;
	logic [11:0] awa, ara;
	logic [31:0] wd, rd_;
	logic [3:0] ws;
	logic [1:0] bresp, rresp, r;
	logic [31:0] d;
	ipoc_pkg::ipoc_pad_t [7:0] p1;
	ipoc_pkg::ipoc_pad_t [1:0] p2;
	logic [1:0] m_out [2][8];
	logic [2:0] m_in [2][8];
	logic p_dir [2];
	logic [2:0] p_idx [2];
	int n_mismatch = 0, total_checks = 0, seed = 32'h1C06;
	localparam logic [11:0] A1 = {ipoc_pkg::REG_PORT1_INDEX, 2'h0};
	localparam logic [11:0] A2 = {ipoc_pkg::REG_PORT2_INDEX, 2'h0};
	initial begin
		clock_i = 0;
		forever #12.5 clock_i = ~clock_i;
	end
	ipoc_top dut_u (.clock_i, .rstn_i, .s_axi_awaddr_i(awa),
		.s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
		.s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
		.s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
		.s_axi_rdata_o(rd_), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv),
		.s_axi_rready_i(rr), .port1_pad_o(p1), .port2_pad_o(p2));
	ipoc_axi_mst mst_u (.clock_i, .awaddr_o(awa), .awvalid_o(awv),
		.awready_i(awr), .wdata_o(wd), .wstrb_o(ws), .wvalid_o(wv),
		.wready_i(wr_), .bresp_i(bresp), .bvalid_i(bv), .bready_o(br),
		.araddr_o(ara), .arvalid_o(arv), .arready_i(arr), .rdata_i(rd_),
		.rresp_i(rresp), .rvalid_i(rv), .rready_o(rr));
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	function automatic ipoc_pkg::ipoc_pad_t pad_exp(logic [1:0] o,
		logic [2:0] i);
		case (i)
			3'h0: return {o, 4'h8};
			3'h1: return {o, 4'hC};
			3'h2: return {o, 4'hA};
			3'h3: return {o, 4'h9};
			default: return {o, 4'h0};
		endcase
	endfunction : pad_exp
	task pads;
		for (int i = 0; i < 8; i++) begin
			chk("port1 pad", p1[i], pad_exp(m_out[0][i], m_in[0][i]));
			if (i < 2)
				chk("port2 pad", p2[i], pad_exp(m_out[1][i], m_in[1][i]));
		end
	endtask : pads
	task op(input int pt, input logic [7:0] v);
		mst_u.wr(pt ? A2 : A1, v, 1'b1, r);
		chk("bresp", r, ipoc_pkg::RESP_OKAY);
		if (v[3]) begin
			p_dir[pt] = v[4];
			p_idx[pt] = v[2:0];
		end else if (pt == 0 || v[2:0] < 2) begin
			if (v[4]) m_in[pt][v[2:0]] = v[7:5];
			else m_out[pt][v[2:0]] = v[6:5];
		end
		pads();
	endtask : op
	task rdb(input int pt);
		logic [7:0] m;
		mst_u.rd(pt ? A2 : A1, d, r);
		m = p_dir[pt] ? m_in[pt][p_idx[pt]] : {1'b0, m_out[pt][p_idx[pt]]};
		if (pt == 1 && p_idx[pt] > 1) m = 3'h0;
		m = {m, p_dir[pt], 1'b0, p_idx[pt]};
		chk("readback", d, {24'h0, m[7:0]});
	endtask : rdb
	// Model state after reset: drive 00, input pull-down, pointer cleared.
	task model_reset;
		foreach (m_out[p, i]) {m_out[p][i], m_in[p][i]} = {2'h0, 3'h1};
		p_dir = '{0, 0};
		p_idx = '{3'h0, 3'h0};
	endtask : model_reset
	task results;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : results
	initial begin
		repeat (20000) @(posedge clock_i);
		n_mismatch++;
		results();
	end
	initial begin
		logic [7:0] v;
		rstn_i = 0;
		model_reset();
		repeat (2) @(posedge clock_i);
		rstn_i <= 1'b1;
		pads();
		rdb(0);
		rdb(1);
		$display("test reset done");
		for (int c = 0; c < 8; c++) begin
			op(0, {c[2:0], 5'h15});
			op(0, {c[2:0], 5'h02});
			op(0, {~c[2:0], 5'h1D});
			rdb(0);
			op(0, {c[2:0], 5'h0A});
			rdb(0);
		end
		$display("test function codes done");
		for (int i = 0; i < 8; i++) begin
			op(1, {3'h3, 2'h2, i[2:0]});
			op(1, {3'h2, 2'h0, i[2:0]});
			op(1, {3'h5, 2'h3, i[2:0]});
			rdb(1);
		end
		$display("test port2 index done");
		mst_u.wr(12'h000, 8'hF0, 1'b1, r);
		chk("unmapped bresp", r, ipoc_pkg::RESP_SLVERR);
		mst_u.rd(12'h004, d, r);
		chk("unmapped rresp", r, ipoc_pkg::RESP_SLVERR);
		chk("unmapped rdata", d, 0);
		mst_u.wr(A1, 8'h70, 1'b0, r);
		chk("no strobe bresp", r, ipoc_pkg::RESP_OKAY);
		pads();
		$display("test refusals done");
		repeat (60) begin
			v = 8'($random(seed));
			if (v[4] && !v[3] && v[7] && v[6:5] != 2'h3) v[7] = 1'b0;
			op(v[0] ^ v[7], v);
			if (v[3]) rdb(v[0] ^ v[7]);
		end
		$display("test random done");
		// A reset in mid-run must bring every mode and the pointer back.
		@(posedge clock_i);
		rstn_i <= 1'b0;
		model_reset();
		repeat (2) @(posedge clock_i);
		rstn_i <= 1'b1;
		pads();
		rdb(0);
		rdb(1);
		$display("test mid-run reset done");
		results();
	end
endmodule : tb
